//--- common/sewp_pkg.sv
package sewp_pkg;
  localparam int ADDR_W = 9;
  localparam int PAGE_BYTES = 4;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD_MASK = 8'hf7;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;
  localparam int OPC_A9_POS = 3;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_WEL_POS = 1;
  localparam int ST_BP_LO_POS = 2;
  localparam int ST_BP_HI_POS = 3;
  localparam int WRDATA_BP_HI_POS = 3;
  localparam int WRDATA_BP_LO_POS = 2;
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic [8:0] PROT_L1_BASE = 9'h180;
  localparam logic [8:0] PROT_L2_BASE = 9'h100;
  localparam logic [8:0] PROT_L3_BASE = 9'h000;
  localparam real PROG_TIME_MS = 15.0;
  localparam real CLK_MHZ = 200.0;
  localparam int PROG_CYCLES = int'(PROG_TIME_MS * 1000.0 * CLK_MHZ);
  typedef enum logic [6:0] {
    SEWP_IDLE = 7'h01,
    SEWP_OPC = 7'h02,
    SEWP_ADDR = 7'h04,
    SEWP_DATA = 7'h08,
    SEWP_STWR = 7'h10,
    SEWP_OUT = 7'h20,
    SEWP_IGNORE = 7'h40
  } sewp_state_t;
endpackage : sewp_pkg

//--- common/sewp_link_if.sv
`timescale 1ns/10ps
interface sewp_link_if;
  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic din;
  modport front (output sel, output sck_rise, output sck_fall, output cs_rise, output cs_fall,
    output din);
  modport core (input sel, input sck_rise, input sck_fall, input cs_rise, input cs_fall,
    input din);
endinterface : sewp_link_if

//--- hw/sewp_sync.sv
`timescale 1ns/10ps
module sewp_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  sewp_link_if.front lnk
);
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [1:0] prev_ff;
  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_ff <= 3'h1;
      s2_ff <= 3'h1;
      prev_ff <= 2'h1;
    end else begin
      s1_ff <= {si_i, sck_i, cs_n_i};
      s2_ff <= s1_ff;
      prev_ff <= s2_ff[1:0];
    end
  end
  assign lnk.sel = !s2_ff[0];
  assign lnk.cs_fall = prev_ff[0] && !s2_ff[0];
  assign lnk.cs_rise = !prev_ff[0] && s2_ff[0];
  assign lnk.sck_rise = !prev_ff[1] && s2_ff[1];
  assign lnk.sck_fall = prev_ff[1] && !s2_ff[1];
  assign lnk.din = s2_ff[2];
endmodule : sewp_sync

//--- hw/sewp_top.sv
`timescale 1ns/10ps
// Contract
// - Protect levels: none, 180-1FF, 100-1FF, all
// - Latch clear at reset; programming needs it
// - Program cycle completion clears the latch
// - Clear-latch command resets the latch
// - Array program needs guard pin and latch
// - Protected addresses are never programmed
// - Program cycle starts on select rising
// - While busy only status read accepted
// - Status bit 0 shows array busy
// - Page write increments two low bits only
// - Over four bytes wraps, overwriting page buffer
// - Latch clear: write discarded at select rise
// - Only select falling restarts decoding
// - Status write programs bits 2 and 3 only
// - Status write needs guard pin and latch
// - Status data: skip four, protect bits, skip two
// - Status bit 0 shows status program busy
// - Decode five of the six instruction opcodes; array read is ignored
// - Sample on rising, drive on falling edge
// - Status read while busy: all ones, busy bit included
// - Status: busy, latch, protect lo, protect hi
module sewp_top
  import sewp_pkg::*;
#(
  parameter int PROG_CNT = sewp_pkg::PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_o,
  output logic prog_we_o,
  output logic [sewp_pkg::ADDR_W-1:0] prog_addr_o,
  output logic [7:0] prog_data_o,
  output logic [1:0] protect_level_o,
  output logic busy_o
);
  import sewp_pkg::*;

  // Strobes use the last page-size cycles of the busy count
  if (PROG_CNT < PAGE_BYTES) begin : g_cnt_check
    $error("PROG_CNT must cover one strobe per page byte");
  end

  sewp_link_if lnk ();
  sewp_state_t state_ff;
  logic [7:0] sh_ff;
  logic [2:0] bit_ff;
  logic [7:0] opc_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0] page_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] loaded_ff;
  logic wel_ff;
  logic [1:0] bp_ff;
  logic [1:0] nxt_bp_ff;
  logic got_data_ff;
  logic at_boundary_ff;
  logic arr_go_ff;
  logic st_go_ff;
  logic [31:0] cnt_ff;
  logic [1:0] wr_idx_ff;
  logic [7:0] out_ff;
  logic wp_s1_ff;
  logic wp_s2_ff;
  logic busy;
  logic byte_done;
  logic [7:0] byte_in;

  sewp_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i),
    .sck_i(sck_i),
    .si_i(si_i),
    .lnk(lnk)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wp_s1_ff <= 1'b0;
      wp_s2_ff <= 1'b0;
    end else begin
      wp_s1_ff <= wp_n_i;
      wp_s2_ff <= wp_s1_ff;
    end
  end

  assign busy = arr_go_ff || st_go_ff;
  assign byte_in = {sh_ff[6:0], lnk.din};
  assign byte_done = lnk.sel && lnk.sck_rise && (bit_ff == 3'h7);

  function automatic logic is_protected(input logic [1:0] lvl, input logic [ADDR_W-1:0] a);
    logic r;
    r = 1'b0;
    case (lvl)
      2'h1: r = (a >= PROT_L1_BASE);
      2'h2: r = (a >= PROT_L2_BASE);
      2'h3: r = (a >= PROT_L3_BASE);
      default: r = 1'b0;
    endcase
    return r;
  endfunction : is_protected

  // Bit shifter: serial input sampled on rising clock edges, MSB first
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sh_ff <= 8'h00;
      bit_ff <= 3'h0;
    end else if (!lnk.sel) begin
      bit_ff <= 3'h0;
    end else if (lnk.sck_rise) begin
      sh_ff <= byte_in;
      bit_ff <= bit_ff + 3'h1;
    end
  end

  // Command sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= SEWP_IDLE;
      opc_ff <= 8'h00;
      addr_ff <= '0;
      loaded_ff <= '0;
      got_data_ff <= 1'b0;
      nxt_bp_ff <= BP_RESET;
      wr_idx_ff <= 2'h0;
    end else if (lnk.cs_fall) begin
      state_ff <= SEWP_OPC;
      // A buffered page must survive a select cycle that arrives while it is programmed
      if (!busy) loaded_ff <= '0;
      got_data_ff <= 1'b0;
    end else if (!lnk.sel) begin
      state_ff <= SEWP_IDLE;
    end else if (byte_done) begin
      case (state_ff)
        SEWP_OPC: begin
          opc_ff <= byte_in;
          if (busy) begin
            state_ff <= (byte_in == OP_STAT_RD) ? SEWP_OUT : SEWP_IGNORE;
          end else if (byte_in == OP_STAT_RD || byte_in == OP_SET_LATCH
                       || byte_in == OP_CLR_LATCH) begin
            state_ff <= SEWP_OUT;
          end else if (byte_in == OP_STAT_WR) begin
            state_ff <= SEWP_STWR;
          end else if ((byte_in & OP_ARR_RD_MASK) == OP_ARR_WR) begin
            addr_ff[8] <= byte_in[OPC_A9_POS];
            state_ff <= SEWP_ADDR;
          end else begin
            state_ff <= SEWP_IGNORE; // Array read and unknown codes are outside this block
          end
        end
        SEWP_ADDR: begin
          addr_ff[7:0] <= byte_in;
          wr_idx_ff <= byte_in[1:0];
          state_ff <= SEWP_DATA;
        end
        SEWP_DATA: begin
          page_ff[wr_idx_ff] <= byte_in;
          loaded_ff[wr_idx_ff] <= 1'b1;
          wr_idx_ff <= wr_idx_ff + 2'h1;
          got_data_ff <= 1'b1;
        end
        SEWP_STWR: begin
          nxt_bp_ff <= {byte_in[WRDATA_BP_HI_POS], byte_in[WRDATA_BP_LO_POS]};
          got_data_ff <= 1'b1;
          state_ff <= SEWP_IGNORE;
        end
        default: state_ff <= state_ff;
      endcase
    end
  end

  // Select may only rise after the rising clock edge that completes a whole byte, before the next rising edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      at_boundary_ff <= 1'b0;
    end else if (!lnk.sel || lnk.sck_rise) begin
      at_boundary_ff <= byte_done;
    end else if (lnk.sck_fall && bit_ff == 3'h0) begin
      at_boundary_ff <= at_boundary_ff;
    end
  end

  // Write-enable latch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wel_ff <= 1'b0;
    end else if (lnk.cs_rise && state_ff == SEWP_OUT && opc_ff == OP_CLR_LATCH && !busy) begin
      wel_ff <= 1'b0;
    end else if (lnk.cs_rise && state_ff == SEWP_OUT && opc_ff == OP_SET_LATCH && !busy) begin
      wel_ff <= 1'b1;
    end else if (busy && cnt_ff == 32'h1) begin
      wel_ff <= 1'b0;
    end
  end

  // Program cycle launch and timer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arr_go_ff <= 1'b0;
      st_go_ff <= 1'b0;
      cnt_ff <= 32'h0;
    end else if (busy) begin
      if (cnt_ff == 32'h1) begin
        arr_go_ff <= 1'b0;
        st_go_ff <= 1'b0;
      end
      cnt_ff <= cnt_ff - 32'h1;
    end else if (lnk.cs_rise && got_data_ff && at_boundary_ff && wel_ff && wp_s2_ff) begin
      if (state_ff == SEWP_DATA) begin
        arr_go_ff <= 1'b1;
        cnt_ff <= 32'(PROG_CNT);
      end else if (opc_ff == OP_STAT_WR) begin
        st_go_ff <= 1'b1;
        cnt_ff <= 32'(PROG_CNT);
      end
    end
  end

  // Block-protect bits update when the status program cycle ends
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bp_ff <= BP_RESET;
    end else if (st_go_ff && cnt_ff == 32'h1) begin
      bp_ff <= nxt_bp_ff;
    end
  end

  // Array programming port: one strobe per loaded, unprotected byte at cycle end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prog_we_o <= 1'b0;
      prog_addr_o <= '0;
      prog_data_o <= 8'h00;
    end else begin
      prog_we_o <= 1'b0;
      if (arr_go_ff && cnt_ff <= 32'(PAGE_BYTES) && cnt_ff != 32'h0) begin
        prog_addr_o <= {addr_ff[8:2], 2'(cnt_ff - 32'h1)};
        prog_data_o <= page_ff[2'(cnt_ff - 32'h1)];
        prog_we_o <= loaded_ff[2'(cnt_ff - 32'h1)]
                     && !is_protected(bp_ff, {addr_ff[8:2], 2'(cnt_ff - 32'h1)});
      end
    end
  end

  // Status output, shifted out on falling clock edges
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_ff <= 8'h00;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else if (!lnk.sel) begin
      so_oe_o <= 1'b0;
    end else if (byte_done && state_ff == SEWP_OPC && byte_in == OP_STAT_RD) begin
      if (busy) begin
        out_ff <= {7'h7f, 1'b1};
      end else begin
        out_ff <= {4'h0, bp_ff[1], bp_ff[0], wel_ff, 1'b0};
      end
    end else if (lnk.sck_fall && state_ff == SEWP_OUT && opc_ff == OP_STAT_RD) begin
      so_o <= out_ff[7];
      so_oe_o <= 1'b1;
      out_ff <= {out_ff[6:0], out_ff[7]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      protect_level_o <= BP_RESET;
      busy_o <= 1'b0;
    end else begin
      protect_level_o <= bp_ff;
      busy_o <= busy;
    end
  end
endmodule : sewp_top

//--- testbench/sewp_top_asserts.sv
`timescale 1ns/10ps
module sewp_top_asserts
  import sewp_pkg::*;
#(
  parameter int PROG_CNT = sewp_pkg::PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic prog_we_o,
  input wire logic [sewp_pkg::ADDR_W-1:0] prog_addr_o,
  input wire logic [7:0] prog_data_o,
  input wire logic [1:0] protect_level_o,
  input wire logic busy_o
);
  int busy_cnt_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) busy_cnt_ff <= 0;
    else if (busy_o) busy_cnt_ff <= busy_cnt_ff + 1;
    else busy_cnt_ff <= 0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  we_in_busy_a: assert property (prog_we_o |-> busy_o)
    else $error("strobe outside busy");
  we_unprot_a: assert property (prog_we_o |-> !(protect_level_o == 2'h3 ||
    (protect_level_o == 2'h2 && prog_addr_o[8]) || (protect_level_o == 2'h1 &&
    prog_addr_o[8:7] == 2'h3))) else $error("protected byte written");
  busy_len_a: assert property ($fell(busy_o) |-> busy_cnt_ff == PROG_CNT)
    else $error("busy length");
  busy_start_a: assert property ($rose(busy_o) |-> (cs_n_i && busy_o) [*8])
    else $error("busy start");
  page_high_a: assert property (prog_we_o && $past(prog_we_o) |->
    prog_addr_o[8:2] == $past(prog_addr_o[8:2])) else $error("page bits moved");
  level_hold_a: assert property (!busy_o && !$past(busy_o) |-> $stable(protect_level_o))
    else $error("level changed idle");
  oe_idle_a: assert property (cs_n_i [*6] |-> !so_oe_o)
    else $error("output while deselected");
  we_late_a: assert property ($rose(prog_we_o) |-> ##[1:4] !busy_o)
    else $error("strobe not at end");
endmodule : sewp_top_asserts

//--- testbench/sewp_spi_master.sv
`timescale 1ns/10ps
module sewp_spi_master (
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic frame(input logic [7:0] b[$], output logic [7:0] rx);
    cs_n_o = 1'b0;
    #125;
    foreach (b[k]) begin
      for (int i = 7; i >= 0; i--) begin
        // Uneven halves keep every pin change on a whole bench clock period
        si_o = b[k][i];
        #65 sck_o = 1'b1;
        rx[i] = so_i;
        #60 sck_o = 1'b0;
      end
    end
    // Select rises in the low phase right after the last bit
    #30 cs_n_o = 1'b1;
    si_o = ~si_o;
    #250;
  endtask : frame
endmodule : sewp_spi_master

//--- testbench/sewp_top_test.sv
`timescale 1ns/10ps
module sewp_top_test;
  import sewp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wp_n_i = 1'b1;
  logic cs_n_i, sck_i, si_i, so_o, so_oe_o, prog_we_o, busy_o;
  logic [ADDR_W-1:0] prog_addr_o;
  logic [7:0] prog_data_o, rx;
  logic [1:0] protect_level_o;
  logic [7:0] mem [512];
  int errors = 0;
  int comparisons = 0;
  int wr_cnt = 0;
  always #2.5 clk_i = ~clk_i;
  sewp_spi_master u_mst (.cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i), .so_i(so_o));
  sewp_top #(.PROG_CNT(2000)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
    .sck_i(sck_i), .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .prog_we_o(prog_we_o), .prog_addr_o(prog_addr_o), .prog_data_o(prog_data_o),
    .protect_level_o(protect_level_o), .busy_o(busy_o));
  always @(negedge clk_i) begin
    if (prog_we_o === 1'b1) begin
      wr_cnt++;
      mem[prog_addr_o] = prog_data_o;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic status(input logic [7:0] exp);
    u_mst.frame('{OP_STAT_RD, 8'h00}, rx);
    check(rx, exp);
  endtask : status
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      stop_test();
    end
  endtask : wait_idle
  task automatic t_refused();
    status(8'h00);
    u_mst.frame('{OP_ARR_WR, 8'h10, 8'h5a}, rx);
    check(busy_o, 0);
    u_mst.frame('{OP_SET_LATCH}, rx);
    u_mst.frame('{OP_CLR_LATCH}, rx);
    status(8'h00);
    u_mst.frame('{OP_SET_LATCH}, rx);
    @(negedge clk_i);
    wp_n_i = 1'b0;
    u_mst.frame('{OP_ARR_WR, 8'h10, 8'h5a}, rx);
    wait_idle();
    check(wr_cnt, 0);
    @(negedge clk_i);
    wp_n_i = 1'b1;
    u_mst.frame('{OP_CLR_LATCH}, rx);
    $display("done t_refused");
  endtask : t_refused
  task automatic t_page();
    u_mst.frame('{OP_SET_LATCH}, rx);
    status(8'h02);
    u_mst.frame('{OP_ARR_WR | 8'h08, 8'h7e, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, rx);
    status(8'hff);
    u_mst.frame('{OP_SET_LATCH}, rx);
    u_mst.frame('{OP_ARR_WR | 8'h08, 8'h7c, 8'h99}, rx);
    wait_idle();
    status(8'h00);
    check(wr_cnt, 4);
    check({mem[9'h17f], mem[9'h17e], mem[9'h17d], mem[9'h17c]}, 32'h22554433);
    $display("done t_page");
  endtask : t_page
  task automatic t_protect();
    u_mst.frame('{OP_SET_LATCH}, rx);
    u_mst.frame('{OP_STAT_WR, 8'hf7}, rx);
    status(8'hff);
    wait_idle();
    check(protect_level_o, 1);
    status(8'h04);
    wr_cnt = 0;
    u_mst.frame('{OP_SET_LATCH}, rx);
    u_mst.frame('{OP_ARR_WR | 8'h08, 8'hfe, 8'h66, 8'h77}, rx);
    wait_idle();
    check(wr_cnt, 0);
    u_mst.frame('{OP_SET_LATCH}, rx);
    u_mst.frame('{OP_ARR_WR | 8'h08, 8'h7c, 8'h88}, rx);
    wait_idle();
    check(wr_cnt, 1);
    check(mem[9'h17c], 8'h88);
    u_mst.frame('{OP_SET_LATCH}, rx);
    u_mst.frame('{OP_STAT_WR, 8'h08}, rx);
    wait_idle();
    check(protect_level_o, 2);
    u_mst.frame('{OP_STAT_WR, 8'h0c}, rx);
    check(busy_o, 0);
    u_mst.frame('{OP_SET_LATCH}, rx);
    u_mst.frame('{OP_ARR_WR | 8'h08, 8'h7d, 8'hcc}, rx);
    wait_idle();
    check(wr_cnt, 1);
    check(protect_level_o, 2);
    $display("done t_protect");
  endtask : t_protect
  initial begin
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_refused();
    t_page();
    t_protect();
    stop_test();
  end
endmodule : sewp_top_test
bind sewp_top sewp_top_asserts #(.PROG_CNT(PROG_CNT)) u_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .wp_n_i(wp_n_i),
  .so_o(so_o), .so_oe_o(so_oe_o), .prog_we_o(prog_we_o), .prog_addr_o(prog_addr_o),
  .prog_data_o(prog_data_o), .protect_level_o(protect_level_o), .busy_o(busy_o));
